/* src/pic_pkg.sv */
package pic_pkg;
  // ****************************************************************
  // port addresses
  // ****************************************************************
  localparam logic [15:0] PORT_LOW = 16'h00C0;
  localparam logic [15:0] PORT_HIGH = 16'h00C2;
  localparam logic [15:0] PORT_RD_LOW = 16'h00C4;
  localparam logic [15:0] PORT_RD_HIGH = 16'h00C6;
  // ****************************************************************
  // first initialization word fields
  // ****************************************************************
  localparam int IW1_START0 = 0;
  localparam int IW1_SINGLE = 1;
  localparam int IW1_EDGE = 3;
  localparam int IW1_START4 = 4;
  // ****************************************************************
  // mode options word fields
  // ****************************************************************
  localparam int IW4_MODE16 = 0;
  localparam int IW4_AUTO_END = 1;
  localparam int IW4_MASTER = 2;
  localparam int IW4_BUFFERED = 3;
  localparam int IW4_SPECIAL_NESTED = 4;
  // ****************************************************************
  // operation word codes (upper five bits or whole byte)
  // ****************************************************************
  localparam logic [4:0] OP_ROT_SPEC_END = 5'h1C;
  localparam logic [4:0] OP_SPEC_END = 5'h0C;
  localparam logic [4:0] OP_SET_PRIO = 5'h18;
  localparam logic [7:0] OP_ROT_AUTO = 8'hA0;
  localparam logic [7:0] OP_END = 8'h20;
  localparam logic [7:0] OP_READ_REQ = 8'h0A;
  localparam logic [7:0] OP_READ_SERV = 8'h0B;
  localparam logic [7:0] RESET_MASK = 8'hFF;
  // ****************************************************************
  // init sequence states
  // ****************************************************************
  typedef enum logic [1:0] {
    PIC_READY = 2'b00,
    PIC_WAIT_VEC = 2'b01,
    PIC_WAIT_CASC = 2'b10,
    PIC_WAIT_OPT = 2'b11
  } pic_init_e;
endpackage

/* src/pic_resolver.sv */
`timescale 1ns/1ps
`default_nettype none
// picks the highest priority set bit of a vector, starting after the bottom level
module pic_resolver #(
  parameter int N = 8
) (
  // inputs
  input wire logic [N-1:0] i_bits,
  input wire logic [2:0] i_bottom,
  // outputs
  output logic o_any,
  output logic [2:0] o_level
);
  always_comb begin
    o_any = 1'b0;
    o_level = 3'h0;
    for (int k = N; k >= 1; k--) begin
      if (i_bits[3'(32'(i_bottom) + k)]) begin
        o_any = 1'b1;
        o_level = 3'(32'(i_bottom) + k);
      end
    end
  end
endmodule
`default_nettype wire

/* src/pic_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - bit 3 selects rising edge requests
// - bits 0 and 4 start init
// - bit 1 single, else cascade word
// - vector base bits 3-7 stored
// - low vector bits give serviced line
// - cascade word only when cascaded
// - master cascade word marks slave lines
// - slave matches identity before driving vector
// - bit 0 selects one vector mode; the code never reads bit 0, the vector is always base plus level
// - auto end of interrupt at acknowledge
// - buffered bit, master bit when buffered
// - bit 4 selects special nested
// - init word order low then high
// - command and status port addresses
// - nested priority after init
// - service bit held until end command
// - A0 selects automatic rotation
// - 20 clears highest service bit
// - specific end with rotation
// - specific end without rotation
// - set bottom priority only
module pic_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // processor port
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // interrupt pins
  input wire logic [7:0] i_req,
  input wire logic i_ack,
  output logic o_int,
  // cascade bus
  input wire logic [2:0] i_cas,
  output logic [2:0] o_cas,
  output logic o_cas_oe,
  // vector data
  output logic [7:0] o_vec,
  output logic o_vec_oe,
  output logic o_buf_en
);
  // ****************************************************************
  // state
  // ****************************************************************
  pic_pkg::pic_init_e init_st, next_init_st;
  logic [7:0] req_s1, req_s2, req_d, ack_s1, ack_s2, cas_s1, cas_s2;
  logic ack_d;
  logic edge_mode, single, auto_end, buffered, master_bit, special_nested, auto_rot, rd_serv;
  logic next_edge_mode, next_single, next_auto_end, next_buffered, next_master_bit;
  logic next_special_nested, next_auto_rot, next_rd_serv;
  logic [4:0] vec_base, next_vec_base;
  logic [7:0] casc_map, next_casc_map, mask, next_mask, pend, next_pend, serv, next_serv;
  logic [2:0] bottom, next_bottom, ack_lvl, next_ack_lvl;
  logic ack_phase, next_ack_phase;
  logic [7:0] next_rdata, next_vec;
  logic next_int, next_vec_oe, next_cas_oe, next_buf_en;
  logic [2:0] next_cas;
  logic req_any, serv_any;
  logic [2:0] req_lvl, serv_lvl;
  logic [7:0] cand;
  logic is_master;
  assign cand = pend & ~mask;
  // ****************************************************************
  // priority resolvers
  // ****************************************************************
  pic_resolver #(.N(8)) u_req (
    .i_bits(cand),
    .i_bottom(bottom),
    .o_any(req_any),
    .o_level(req_lvl)
  );
  pic_resolver #(.N(8)) u_serv (
    .i_bits(serv),
    .i_bottom(bottom),
    .o_any(serv_any),
    .o_level(serv_lvl)
  );
  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic wr_lo;
    logic wr_hi;
    logic blocked;
    logic [7:0] lvl_bit;
    logic [7:0] lvl_ok;
    logic [7:0] seen;
    wr_lo = i_wr && (i_addr == pic_pkg::PORT_LOW);
    wr_hi = i_wr && (i_addr == pic_pkg::PORT_HIGH);
    lvl_bit = 8'h01 << i_wdata[2:0];
    seen = 8'h00;
    lvl_ok = 8'h00;
    blocked = 1'b0;
    next_init_st = init_st;
    next_edge_mode = edge_mode;
    next_single = single;
    next_auto_end = auto_end;
    next_buffered = buffered;
    next_master_bit = master_bit;
    next_special_nested = special_nested;
    next_auto_rot = auto_rot;
    next_rd_serv = rd_serv;
    next_vec_base = vec_base;
    next_casc_map = casc_map;
    next_mask = mask;
    next_serv = serv;
    next_bottom = bottom;
    next_ack_lvl = ack_lvl;
    next_ack_phase = ack_phase;
    next_cas = o_cas;
    next_cas_oe = 1'b0;
    next_vec = o_vec;
    next_vec_oe = 1'b0;
    next_buf_en = buffered;
    is_master = buffered ? master_bit : single;
    seen = edge_mode ? (req_s2 & ~req_d) : req_s2;
    next_pend = edge_mode ? (pend | seen) : (pend & req_s2) | seen;
    for (int k = 1; k <= 8; k++) begin
      if (serv[3'(32'(bottom) + k)]) begin
        if (special_nested && casc_map[3'(32'(bottom) + k)] && !single) begin
          lvl_ok[3'(32'(bottom) + k)] = ~blocked;
        end
        blocked = 1'b1;
      end else begin
        lvl_ok[3'(32'(bottom) + k)] = ~blocked;
      end
    end
    next_int = req_any && lvl_ok[req_lvl] && (init_st == pic_pkg::PIC_READY);
    // acknowledge sequence, two pulses
    if (ack_s2[0] && !ack_d) begin
      if (!ack_phase) begin
        next_ack_phase = 1'b1;
        next_ack_lvl = req_lvl;
        if (req_any) begin
          next_serv[req_lvl] = 1'b1;
          // a new edge in the acknowledge cycle is kept
          next_pend[req_lvl] = seen[req_lvl];
        end
        if (is_master && casc_map[req_lvl] && !single) begin
          next_cas = req_lvl;
          next_cas_oe = 1'b1;
        end
      end else begin
        next_ack_phase = 1'b0;
        if (auto_end) begin
          next_serv[ack_lvl] = 1'b0;
          if (auto_rot) begin
            next_bottom = ack_lvl;
          end
        end
        if ((is_master && (single || !casc_map[ack_lvl])) ||
            (!is_master && !single && cas_s2[2:0] == casc_map[2:0])) begin
          next_vec = {vec_base, ack_lvl};
          next_vec_oe = 1'b1;
        end
      end
    end
    if (ack_phase && is_master && casc_map[ack_lvl] && !single) begin
      next_cas_oe = 1'b1;
    end
    if (wr_lo && i_wdata[pic_pkg::IW1_START0] && i_wdata[pic_pkg::IW1_START4]) begin
      next_init_st = pic_pkg::PIC_WAIT_VEC;
      next_edge_mode = i_wdata[pic_pkg::IW1_EDGE];
      next_single = i_wdata[pic_pkg::IW1_SINGLE];
      next_mask = 8'h00;
      next_serv = 8'h00;
      next_pend = 8'h00;
      next_bottom = 3'h7;
      next_auto_rot = 1'b0;
      next_rd_serv = 1'b0;
      next_ack_phase = 1'b0;
    end else if (wr_lo && init_st == pic_pkg::PIC_READY) begin
      if (i_wdata == pic_pkg::OP_ROT_AUTO) begin
        next_auto_rot = 1'b1;
      end else if (i_wdata == pic_pkg::OP_END) begin
        if (serv_any) begin
          next_serv[serv_lvl] = 1'b0;
          if (auto_rot) begin
            next_bottom = serv_lvl;
          end
        end
      end else if (i_wdata[7:3] == pic_pkg::OP_ROT_SPEC_END) begin
        next_serv = next_serv & ~lvl_bit;
        next_bottom = i_wdata[2:0];
      end else if (i_wdata[7:3] == pic_pkg::OP_SPEC_END) begin
        next_serv = next_serv & ~lvl_bit;
      end else if (i_wdata[7:3] == pic_pkg::OP_SET_PRIO) begin
        next_bottom = i_wdata[2:0];
      end else if (i_wdata == pic_pkg::OP_READ_REQ) begin
        next_rd_serv = 1'b0;
      end else if (i_wdata == pic_pkg::OP_READ_SERV) begin
        next_rd_serv = 1'b1;
      end
    end else if (wr_hi) begin
      case (init_st)
        pic_pkg::PIC_WAIT_VEC: begin
          next_vec_base = i_wdata[7:3];
          next_init_st = single ? pic_pkg::PIC_WAIT_OPT : pic_pkg::PIC_WAIT_CASC;
        end
        pic_pkg::PIC_WAIT_CASC: begin
          next_casc_map = i_wdata;
          next_init_st = pic_pkg::PIC_WAIT_OPT;
        end
        pic_pkg::PIC_WAIT_OPT: begin
          next_auto_end = i_wdata[pic_pkg::IW4_AUTO_END];
          next_buffered = i_wdata[pic_pkg::IW4_BUFFERED];
          next_master_bit = i_wdata[pic_pkg::IW4_MASTER] & i_wdata[pic_pkg::IW4_BUFFERED];
          next_special_nested = i_wdata[pic_pkg::IW4_SPECIAL_NESTED];
          next_init_st = pic_pkg::PIC_READY;
        end
        default: begin
          next_mask = i_wdata;
        end
      endcase
    end
    next_rdata = 8'h00;
    if (i_rd && i_addr == pic_pkg::PORT_RD_LOW) begin
      next_rdata = rd_serv ? serv : pend;
    end else if (i_rd && i_addr == pic_pkg::PORT_RD_HIGH) begin
      next_rdata = mask;
    end
  end
  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    req_s1 <= i_req;
    req_s2 <= req_s1;
    ack_s1 <= {7'h00, i_ack};
    ack_s2 <= ack_s1;
    cas_s1 <= {5'h00, i_cas};
    cas_s2 <= cas_s1;
    if (!i_rst_n) begin
      init_st <= pic_pkg::PIC_READY;
      req_d <= 8'h00;
      ack_d <= 1'b0;
      edge_mode <= 1'b0;
      single <= 1'b1;
      auto_end <= 1'b0;
      buffered <= 1'b0;
      master_bit <= 1'b0;
      special_nested <= 1'b0;
      auto_rot <= 1'b0;
      rd_serv <= 1'b0;
      vec_base <= 5'h00;
      casc_map <= 8'h00;
      mask <= pic_pkg::RESET_MASK;
      pend <= 8'h00;
      serv <= 8'h00;
      bottom <= 3'h7;
      ack_lvl <= 3'h0;
      ack_phase <= 1'b0;
      o_rdata <= 8'h00;
      o_int <= 1'b0;
      o_cas <= 3'h0;
      o_cas_oe <= 1'b0;
      o_vec <= 8'h00;
      o_vec_oe <= 1'b0;
      o_buf_en <= 1'b0;
    end else begin
      init_st <= next_init_st;
      req_d <= req_s2;
      ack_d <= ack_s2[0];
      edge_mode <= next_edge_mode;
      single <= next_single;
      auto_end <= next_auto_end;
      buffered <= next_buffered;
      master_bit <= next_master_bit;
      special_nested <= next_special_nested;
      auto_rot <= next_auto_rot;
      rd_serv <= next_rd_serv;
      vec_base <= next_vec_base;
      casc_map <= next_casc_map;
      mask <= next_mask;
      pend <= next_pend;
      serv <= next_serv;
      bottom <= next_bottom;
      ack_lvl <= next_ack_lvl;
      ack_phase <= next_ack_phase;
      o_rdata <= next_rdata;
      o_int <= next_int;
      o_cas <= next_cas;
      o_cas_oe <= next_cas_oe;
      o_vec <= next_vec;
      o_vec_oe <= next_vec_oe;
      o_buf_en <= next_buf_en;
    end
  end
endmodule
`default_nettype wire

/* verif/pic_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pic_host_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // start of one acknowledge sequence
  input wire logic i_go,
  // acknowledge pin
  output logic o_ack,
  output logic o_busy
);
  logic [3:0] step;
  logic [3:0] next_step;
  always_comb begin
    next_step = step;
    if (step != 4'h0) next_step = (step == 4'hC) ? 4'h0 : step + 4'h1;
    else if (i_go) next_step = 4'h1;
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) step <= 4'h0;
    else step <= next_step;
  end
  assign o_ack = (step inside {4'h1, 4'h2, 4'h7, 4'h8});
  assign o_busy = (step != 4'h0);
endmodule
`default_nettype wire

/* verif/pic_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module pic_top_sva (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // processor port
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  // interrupt pins
  input wire logic i_ack,
  input wire logic o_int,
  input wire logic [7:0] o_vec,
  input wire logic o_vec_oe,
  input wire logic o_buf_en
);
  logic [1:0] st;
  logic single;
  logic [4:0] base;
  logic [7:0] mask;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ****************************************************************
  // shadow of the init sequence
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st <= 2'h0;
      single <= 1'b1;
      base <= 5'h00;
      mask <= 8'hFF;
    end else if (i_wr && i_addr == pic_pkg::PORT_LOW && i_wdata[0] && i_wdata[4]) begin
      st <= 2'h1;
      single <= i_wdata[1];
      mask <= 8'h00;
    end else if (i_wr && i_addr == pic_pkg::PORT_HIGH) begin
      if (st == 2'h0) mask <= i_wdata;
      if (st == 2'h1) base <= i_wdata[7:3];
      st <= (st == 2'h1 && single) ? 2'h3 : ((st == 2'h0) ? 2'h0 : st + 2'h1);
    end
  end
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero while idle");
  a_rdata_unmapped: assert property ($past(i_rd) && $past(i_addr) != pic_pkg::PORT_RD_LOW
    && $past(i_addr) != pic_pkg::PORT_RD_HIGH |-> o_rdata == 8'h00) else $error("unmapped read not zero");
  a_mask_read: assert property ($past(i_rd) && $past(i_addr) == pic_pkg::PORT_RD_HIGH
    |-> o_rdata == $past(mask)) else $error("mask read wrong");
  a_vec_base: assert property (o_vec_oe |-> o_vec[7:3] == base)
    else $error("vector base wrong");
  a_vec_pulse: assert property (o_vec_oe |=> !o_vec_oe)
    else $error("vector enable longer than one cycle");
  a_vec_ack_delay: assert property (o_vec_oe |-> $past(i_ack, 3) && !$past(i_ack, 4))
    else $error("vector not three cycles after acknowledge");
  a_buf_write: assert property ($changed(o_buf_en) |-> $past(i_wr, 2) &&
    $past(i_addr, 2) == pic_pkg::PORT_HIGH) else $error("buffer flag moved");
  a_int_masked: assert property ((mask == 8'hFF) [*8] |-> !o_int)
    else $error("interrupt while all masked");
endmodule
bind pic_top pic_top_sva chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
  .i_wdata(i_wdata), .o_rdata(o_rdata), .i_ack(i_ack), .o_int(o_int), .o_vec(o_vec), .o_vec_oe(o_vec_oe),
  .o_buf_en(o_buf_en));
`default_nettype wire

/* verif/pic_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error at %0t got %h exp %h", $time, g, e); end end
module pic_top_tb;
  logic i_clk, i_rst_n, i_wr, i_rd, i_ack, go, busy, o_int, o_cas_oe, o_vec_oe, o_buf_en;
  logic [15:0] i_addr;
  logic [7:0] i_wdata, i_req, o_rdata, o_vec, vec_seen;
  logic [2:0] i_cas, o_cas, cas_seen;
  int n_mismatch = 0, compares = 0, vec_cnt = 0, cas_cnt = 0;
  always #5 i_clk = ~i_clk;
  pic_top dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .i_req(i_req), .i_ack(i_ack), .o_int(o_int), .i_cas(i_cas), .o_cas(o_cas),
    .o_cas_oe(o_cas_oe), .o_vec(o_vec), .o_vec_oe(o_vec_oe), .o_buf_en(o_buf_en));
  pic_host_model host_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_go(go), .o_ack(i_ack), .o_busy(busy));
  always @(posedge i_clk) begin
    if (o_vec_oe === 1'b1) begin
      vec_seen <= o_vec;
      vec_cnt <= vec_cnt + 1;
    end
    if (o_cas_oe === 1'b1) begin
      cas_seen <= o_cas;
      cas_cnt <= cas_cnt + 1;
    end
  end
  // ****************************************************************
  // bus tasks
  // ****************************************************************
  task end_of_test;
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk) begin i_addr <= a; i_wdata <= d; i_wr <= 1'b1; end
    @(posedge i_clk) i_wr <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_clk) begin i_addr <= a; i_rd <= 1'b1; end
    @(posedge i_clk) i_rd <= 1'b0;
    #1 `CHK(o_rdata, e)
  endtask
  task wait_int;
    for (int i = 0; i < 30 && o_int !== 1'b1; i++) @(posedge i_clk);
    `CHK(o_int, 1'b1)
  endtask
  task ack_chk(input logic [7:0] e, input bit hit);
    int c;
    while (busy === 1'b1) @(posedge i_clk);
    wait_int;
    c = vec_cnt;
    @(posedge i_clk) go <= 1'b1;
    @(posedge i_clk) go <= 1'b0;
    repeat (20) @(posedge i_clk);
    if (hit) begin
      `CHK(vec_cnt, c + 1)
      `CHK(vec_seen, e)
    end else `CHK(vec_cnt, c)
  endtask
  task t_single_init;
    wr(16'h00C0, 8'h13);
    wr(16'h00C2, 8'h08);
    wr(16'h00C2, 8'h1D);
    wr(16'h00C2, 8'h00);
    rd(16'h00C6, 8'h00);
    rd(16'h00C8, 8'h00);
    `CHK(o_buf_en, 1'b1)
  endtask
  task t_vector_eoi;
    @(posedge i_clk) i_req <= 8'h20;
    ack_chk(8'h0D, 1'b1);
    @(posedge i_clk) i_req <= 8'h00;
    wr(16'h00C0, 8'h0B);
    rd(16'h00C4, 8'h20);
    wr(16'h00C0, 8'h20);
    rd(16'h00C4, 8'h00);
  endtask
  task t_rotation;
    @(posedge i_clk) i_req <= 8'h44;
    ack_chk(8'h0A, 1'b1);
    wr(16'h00C0, 8'h62);
    rd(16'h00C4, 8'h00);
    ack_chk(8'h0A, 1'b1);
    wr(16'h00C0, 8'hC6);
    rd(16'h00C4, 8'h04);
    wr(16'h00C0, 8'hE2);
    rd(16'h00C4, 8'h00);
    ack_chk(8'h0E, 1'b1);
    wr(16'h00C0, 8'hA0);
    wr(16'h00C0, 8'h20);
    ack_chk(8'h0A, 1'b1);
    @(posedge i_clk) i_req <= 8'h00;
    wr(16'h00C0, 8'h20);
  endtask
  task t_edge_auto;
    wr(16'h00C0, 8'h1B);
    wr(16'h00C2, 8'h08);
    wr(16'h00C2, 8'h1F);
    wr(16'h00C2, 8'h00);
    @(posedge i_clk) i_req <= 8'h02;
    ack_chk(8'h09, 1'b1);
    wr(16'h00C0, 8'h0B);
    rd(16'h00C4, 8'h00);
    repeat (10) @(posedge i_clk);
    `CHK(o_int, 1'b0)
    @(posedge i_clk) i_req <= 8'h00;
  endtask
  task t_master_casc;
    `CHK(cas_cnt, 0)
    wr(16'h00C0, 8'h11);
    wr(16'h00C2, 8'h08);
    wr(16'h00C2, 8'h04);
    wr(16'h00C2, 8'h1D);
    wr(16'h00C2, 8'h00);
    @(posedge i_clk) i_req <= 8'h04;
    ack_chk(8'h00, 1'b0);
    `CHK(cas_seen, 3'h2)
    `CHK(cas_cnt > 0, 1'b1)
    `CHK(o_cas_oe, 1'b0)
    `CHK(o_int, 1'b1)
    @(posedge i_clk) i_req <= 8'h00;
    wr(16'h00C0, 8'h20);
    `CHK(o_buf_en, 1'b1)
  endtask
  task t_slave_match;
    wr(16'h00C0, 8'h11);
    wr(16'h00C2, 8'h10);
    wr(16'h00C2, 8'h03);
    wr(16'h00C2, 8'h01);
    wr(16'h00C2, 8'h00);
    rd(16'h00C6, 8'h00);
    `CHK(o_buf_en, 1'b0)
    @(posedge i_clk) begin i_cas <= 3'h5; i_req <= 8'h01; end
    ack_chk(8'h00, 1'b0);
    wr(16'h00C0, 8'h20);
    @(posedge i_clk) i_cas <= 3'h3;
    ack_chk(8'h10, 1'b1);
    wr(16'h00C0, 8'h20);
    wr(16'h00C0, 8'h0A);
    rd(16'h00C4, 8'h01);
    wr(16'h00C2, 8'hFF);
    repeat (12) @(posedge i_clk);
    `CHK(o_int, 1'b0)
    rd(16'h00C6, 8'hFF);
  endtask
  initial begin
    i_clk = 1'b0;
    i_rst_n = 1'b0;
    {i_wr, i_rd, go, i_addr, i_wdata, i_req, i_cas, vec_seen, cas_seen} = '0;
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_single_init;
    t_vector_eoi;
    t_rotation;
    t_edge_auto;
    t_master_casc;
    t_slave_match;
    end_of_test;
  end
  // the scenarios need well under a thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    end_of_test;
  end
endmodule
`default_nettype wire
